// [rtl/ssu_unit.sv]
// Single-cycle saturating add and subtract datapath with sticky saturation flag.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Signed add or subtract clamps to the signed range of 32, 16 or 8 bits.
// - Clamped full-width signed add or subtract sets the sticky flag, else unchanged.
// - Byte and halfword signed lane operations never change the sticky flag.
// - Only reset or a status register write clears the flag; arithmetic never clears it.
// - Software sees the flag through the SAT_FLAG output port.
// - None of these operations alter the negative, zero, carry, overflow flags.
// - Lane operations work independently per byte or halfword into matching lanes.
// - Signed add-sub exchange: top a.hi+b.lo, bottom a.lo-b.hi, signed 16.
// - Signed sub-add exchange: top a.hi-b.lo, bottom a.lo+b.hi, signed 16.
// - Doubling add doubles operand b and adds it to operand a.
// - Doubling subtract doubles operand b and subtracts it from operand a.
// - Doubling and sum both saturate to signed 32; either sets the flag.
// - Unsigned add-sub exchange: top a.hi+b.lo, bottom a.lo-b.hi, unsigned 16.
// - Unsigned sub-add exchange: top a.hi-b.lo, bottom a.lo+b.hi, unsigned 16.
// - Unsigned halfword add clamps each sum to zero through 65535.
// - Unsigned byte add clamps each of four sums to zero through 255.
// - Unsigned halfword subtract clamps each difference, negatives become zero.
// - Unsigned byte subtract clamps each byte difference to zero through 255.
module ssu_unit
    import ssu_pkg::*;
(
    input  wire logic        REF_CLK,
    input  wire logic        RST_N,
    input  wire ssu_req_s    REQ,
    input  wire logic        STATUS_WR,
    input  wire logic        STATUS_WR_SAT,
    input  wire logic [3:0]  NZCV_IN,
    output var  ssu_rsp_s    RSP,
    output var  logic        SAT_FLAG,
    output var  logic [3:0]  NZCV_OUT
);
    logic [31:0] dbl_val;
    logic        dbl_sat;
    logic [31:0] b_eff;
    logic        add_sub;
    logic        add_sgn;
    logic [31:0] w_y;
    logic        w_sat;
    logic        h_sub   [2];
    logic        h_sgn;
    logic [15:0] h_a     [2];
    logic [15:0] h_b     [2];
    logic [15:0] h_y     [2];
    logic        h_sat   [2];
    logic        b_sub;
    logic        b_sgn;
    logic [7:0]  b_y     [4];
    logic        b_sat   [4];
    logic [31:0] result_d;
    logic        sat_ev_d;
    logic        any_sat_d;
    ssu_rsp_s    rsp_q;
    logic        sat_flag_q;
    logic [3:0]  nzcv_q;
    ssu_op_e     op;

    assign op = REQ.op;

    // Doubling step saturated to signed 32 bits.
    ssu_lane #(.W(32)) u_dbl (
        .a   (REQ.opnd_b),
        .b   (REQ.opnd_b),
        .sub (1'b0),
        .sgn (1'b1),
        .y   (dbl_val),
        .sat (dbl_sat)
    );

    always_comb begin
        b_eff   = REQ.opnd_b;
        add_sub = 1'b0;
        add_sgn = 1'b1;
        case (op)
            SSU_OP_SIGNED_SAT_SUB: begin
                add_sub = 1'b1;
            end
            SSU_OP_DOUBLING_SAT_ADD: begin
                b_eff = dbl_val;
            end
            SSU_OP_DOUBLING_SAT_SUB: begin
                b_eff   = dbl_val;
                add_sub = 1'b1;
            end
            default: begin
                add_sub = 1'b0;
            end
        endcase
    end

    // Full-width signed add or subtract.
    ssu_lane #(.W(32)) u_word (
        .a   (REQ.opnd_a),
        .b   (b_eff),
        .sub (add_sub),
        .sgn (add_sgn),
        .y   (w_y),
        .sat (w_sat)
    );

    // Halfword lane controls, index 1 is the top halfword.
    always_comb begin
        h_a[1]   = REQ.opnd_a[31:16];
        h_a[0]   = REQ.opnd_a[15:0];
        h_b[1]   = REQ.opnd_b[31:16];
        h_b[0]   = REQ.opnd_b[15:0];
        h_sub[1] = 1'b0;
        h_sub[0] = 1'b0;
        h_sgn    = 1'b1;
        case (op)
            SSU_OP_SIGNED_SAT_SUB_HALVES: begin
                h_sub[1] = 1'b1;
                h_sub[0] = 1'b1;
            end
            SSU_OP_SIGNED_ADD_SUB_EXCHANGE: begin
                h_b[1]   = REQ.opnd_b[15:0];
                h_b[0]   = REQ.opnd_b[31:16];
                h_sub[0] = 1'b1;
            end
            SSU_OP_SIGNED_SUB_ADD_EXCHANGE: begin
                h_b[1]   = REQ.opnd_b[15:0];
                h_b[0]   = REQ.opnd_b[31:16];
                h_sub[1] = 1'b1;
            end
            SSU_OP_UNSIGNED_ADD_SUB_EXCHANGE: begin
                h_b[1]   = REQ.opnd_b[15:0];
                h_b[0]   = REQ.opnd_b[31:16];
                h_sub[0] = 1'b1;
                h_sgn    = 1'b0;
            end
            SSU_OP_UNSIGNED_SUB_ADD_EXCHANGE: begin
                h_b[1]   = REQ.opnd_b[15:0];
                h_b[0]   = REQ.opnd_b[31:16];
                h_sub[1] = 1'b1;
                h_sgn    = 1'b0;
            end
            SSU_OP_UNSIGNED_SAT_ADD_HALVES: begin
                h_sgn = 1'b0;
            end
            SSU_OP_UNSIGNED_SAT_SUB_HALVES: begin
                h_sub[1] = 1'b1;
                h_sub[0] = 1'b1;
                h_sgn    = 1'b0;
            end
            default: begin
                h_sgn = 1'b1;
            end
        endcase
    end

    // Byte lane controls.
    always_comb begin
        b_sub = 1'b0;
        b_sgn = 1'b1;
        case (op)
            SSU_OP_SIGNED_SAT_SUB_BYTES: begin
                b_sub = 1'b1;
            end
            SSU_OP_UNSIGNED_SAT_ADD_BYTES: begin
                b_sgn = 1'b0;
            end
            SSU_OP_UNSIGNED_SAT_SUB_BYTES: begin
                b_sub = 1'b1;
                b_sgn = 1'b0;
            end
            default: begin
                b_sub = 1'b0;
            end
        endcase
    end

    // Independent halfword and byte lanes.
    for (genvar gh = 0; gh < 2; gh++) begin : g_half
        ssu_lane #(.W(16)) u_half (
            .a   (h_a[gh]),
            .b   (h_b[gh]),
            .sub (h_sub[gh]),
            .sgn (h_sgn),
            .y   (h_y[gh]),
            .sat (h_sat[gh])
        );
    end

    for (genvar gb = 0; gb < 4; gb++) begin : g_byte
        ssu_lane #(.W(8)) u_byte (
            .a   (REQ.opnd_a[gb*8 +: 8]),
            .b   (REQ.opnd_b[gb*8 +: 8]),
            .sub (b_sub),
            .sgn (b_sgn),
            .y   (b_y[gb]),
            .sat (b_sat[gb])
        );
    end

    // Result select and saturation event.
    always_comb begin
        result_d  = w_y;
        sat_ev_d  = 1'b0;
        any_sat_d = 1'b0;
        case (op)
            SSU_OP_SIGNED_SAT_ADD,
            SSU_OP_SIGNED_SAT_SUB: begin
                result_d  = w_y;
                sat_ev_d  = w_sat;
                any_sat_d = w_sat;
            end
            SSU_OP_DOUBLING_SAT_ADD,
            SSU_OP_DOUBLING_SAT_SUB: begin
                result_d  = w_y;
                sat_ev_d  = w_sat | dbl_sat;
                any_sat_d = w_sat | dbl_sat;
            end
            SSU_OP_SIGNED_SAT_ADD_HALVES,
            SSU_OP_SIGNED_SAT_SUB_HALVES,
            SSU_OP_SIGNED_ADD_SUB_EXCHANGE,
            SSU_OP_SIGNED_SUB_ADD_EXCHANGE,
            SSU_OP_UNSIGNED_ADD_SUB_EXCHANGE,
            SSU_OP_UNSIGNED_SUB_ADD_EXCHANGE,
            SSU_OP_UNSIGNED_SAT_ADD_HALVES,
            SSU_OP_UNSIGNED_SAT_SUB_HALVES: begin
                result_d  = {h_y[1], h_y[0]};
                sat_ev_d  = 1'b0;
                any_sat_d = h_sat[1] | h_sat[0];
            end
            SSU_OP_SIGNED_SAT_ADD_BYTES,
            SSU_OP_SIGNED_SAT_SUB_BYTES,
            SSU_OP_UNSIGNED_SAT_ADD_BYTES,
            SSU_OP_UNSIGNED_SAT_SUB_BYTES: begin
                result_d  = {b_y[3], b_y[2], b_y[1], b_y[0]};
                sat_ev_d  = 1'b0;
                any_sat_d = b_sat[3] | b_sat[2] | b_sat[1] | b_sat[0];
            end
            default: begin
                result_d = w_y;
            end
        endcase
    end

    // Registered response.
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rsp_q.valid     <= 1'b0;
            rsp_q.result    <= SSU_RESULT_RST;
            rsp_q.saturated <= 1'b0;
        end else begin
            rsp_q.valid     <= REQ.valid;
            rsp_q.result    <= REQ.valid ? result_d : rsp_q.result;
            rsp_q.saturated <= REQ.valid & any_sat_d;
        end
    end

    // Sticky flag: a saturation in the same cycle as a write wins.
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sat_flag_q <= SSU_SAT_FLAG_RST;
        end else if (REQ.valid && sat_ev_d) begin
            sat_flag_q <= 1'b1;
        end else if (STATUS_WR) begin
            sat_flag_q <= STATUS_WR_SAT;
        end
    end

    // Condition flags pass through untouched by these operations.
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            nzcv_q <= SSU_NZCV_RST;
        end else begin
            nzcv_q <= NZCV_IN;
        end
    end

    assign RSP      = rsp_q;
    assign SAT_FLAG = sat_flag_q;
    assign NZCV_OUT = nzcv_q;
endmodule // ssu_unit
`default_nettype wire

// [rtl/ssu_pkg.sv]
// Package with operation codes, carriers and reset values for the saturating unit.
package ssu_pkg;

    localparam int SSU_WIDTH = 32;
    localparam int SSU_OP_W  = 5;
    localparam logic SSU_SAT_FLAG_RST = 1'h0;
    localparam logic [31:0] SSU_RESULT_RST = 32'h0000_0000;
    localparam logic [3:0]  SSU_NZCV_RST   = 4'h0;

    typedef enum logic [4:0] {
        SSU_OP_SIGNED_SAT_ADD            = 5'h00,
        SSU_OP_SIGNED_SAT_SUB            = 5'h01,
        SSU_OP_SIGNED_SAT_ADD_BYTES      = 5'h02,
        SSU_OP_SIGNED_SAT_ADD_HALVES     = 5'h03,
        SSU_OP_SIGNED_SAT_SUB_BYTES      = 5'h04,
        SSU_OP_SIGNED_SAT_SUB_HALVES     = 5'h05,
        SSU_OP_SIGNED_ADD_SUB_EXCHANGE   = 5'h06,
        SSU_OP_SIGNED_SUB_ADD_EXCHANGE   = 5'h07,
        SSU_OP_DOUBLING_SAT_ADD          = 5'h08,
        SSU_OP_DOUBLING_SAT_SUB          = 5'h09,
        SSU_OP_UNSIGNED_ADD_SUB_EXCHANGE = 5'h0A,
        SSU_OP_UNSIGNED_SUB_ADD_EXCHANGE = 5'h0B,
        SSU_OP_UNSIGNED_SAT_ADD_BYTES    = 5'h0C,
        SSU_OP_UNSIGNED_SAT_ADD_HALVES   = 5'h0D,
        SSU_OP_UNSIGNED_SAT_SUB_BYTES    = 5'h0E,
        SSU_OP_UNSIGNED_SAT_SUB_HALVES   = 5'h0F
    } ssu_op_e;

    typedef struct packed {
        logic        valid;
        ssu_op_e     op;
        logic [31:0] opnd_a;
        logic [31:0] opnd_b;
    } ssu_req_s;

    typedef struct packed {
        logic        valid;
        logic [31:0] result;
        logic        saturated;
    } ssu_rsp_s;

endpackage : ssu_pkg

// [rtl/ssu_lane.sv]
// One saturating add or subtract lane of configurable width.
`timescale 1ns/100ps
`default_nettype none
module ssu_lane #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] a,
    input  wire logic [W-1:0] b,
    input  wire logic         sub,
    input  wire logic         sgn,
    output var  logic [W-1:0] y,
    output var  logic         sat
);
    logic [W:0] ext_a;
    logic [W:0] ext_b;
    logic [W:0] raw;

    // Refuses a lane too narrow to hold a sign bit and a magnitude.
    if (W < 2) begin : g_bad_width
        $error("ssu_lane width too small");
    end

    always_comb begin
        ext_a = {sgn & a[W-1], a};
        ext_b = {sgn & b[W-1], b};
        raw   = sub ? (ext_a - ext_b) : (ext_a + ext_b);
        y     = raw[W-1:0];
        sat   = 1'b0;
        if (sgn) begin
            if (raw[W] != raw[W-1]) begin
                sat = 1'b1;
                y   = raw[W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
            end
        end else if (raw[W]) begin
            sat = 1'b1;
            y   = sub ? {W{1'b0}} : {W{1'b1}};
        end
    end
endmodule // ssu_lane
`default_nettype wire

// [testbench/ssu_unit_properties.sv]
// Concurrent checks on the ports of the saturating unit.
`timescale 1ns/100ps
`default_nettype none
module ssu_checker
    import ssu_pkg::*;
(
    input wire logic       REF_CLK,
    input wire logic       RST_N,
    input wire ssu_req_s   REQ,
    input wire logic       STATUS_WR,
    input wire logic       STATUS_WR_SAT,
    input wire logic [3:0] NZCV_IN,
    input wire ssu_rsp_s   RSP,
    input wire logic       SAT_FLAG,
    input wire logic [3:0] NZCV_OUT
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    logic        wide_op;
    logic        add_op;
    logic        a_sign;
    logic [31:0] sum_ab;
    assign wide_op = REQ.valid && (REQ.op inside {SSU_OP_SIGNED_SAT_ADD, SSU_OP_SIGNED_SAT_SUB,
                     SSU_OP_DOUBLING_SAT_ADD, SSU_OP_DOUBLING_SAT_SUB});
    assign add_op  = REQ.valid && (REQ.op == SSU_OP_SIGNED_SAT_ADD);
    assign a_sign  = REQ.opnd_a[31];
    assign sum_ab  = REQ.opnd_a + REQ.opnd_b;
    property p_answer; REQ.valid |=> RSP.valid; endproperty
    property p_quiet; !REQ.valid && !STATUS_WR |=> !RSP.valid && $stable(SAT_FLAG); endproperty
    property p_nzcv; 1'b1 |=> NZCV_OUT == $past(NZCV_IN); endproperty
    property p_sticky; SAT_FLAG && !STATUS_WR |=> SAT_FLAG; endproperty
    property p_lane_flag; REQ.valid && !wide_op && !STATUS_WR |=> $stable(SAT_FLAG); endproperty
    property p_wide_flag;
        wide_op && !STATUS_WR |=> SAT_FLAG == ($past(SAT_FLAG) || RSP.saturated);
    endproperty
    property p_clear; STATUS_WR && !STATUS_WR_SAT && !wide_op |=> !SAT_FLAG; endproperty
    property p_add_mixed;
        add_op && (REQ.opnd_a[31] != REQ.opnd_b[31])
        |=> RSP.result == $past(sum_ab) && !RSP.saturated;
    endproperty
    property p_add_ovf;
        add_op && (REQ.opnd_a[31] == REQ.opnd_b[31]) && (sum_ab[31] != a_sign)
        |=> RSP.saturated && RSP.result == {$past(a_sign), {31{!$past(a_sign)}}};
    endproperty
    a_answer: assert property (p_answer) else $error("no answer after request");
    a_quiet: assert property (p_quiet) else $error("activity without request");
    a_nzcv: assert property (p_nzcv) else $error("condition flags altered");
    a_sticky: assert property (p_sticky) else $error("flag dropped without write");
    a_lane_flag: assert property (p_lane_flag) else $error("lane op moved flag");
    a_wide_flag: assert property (p_wide_flag) else $error("wide op flag wrong");
    a_clear: assert property (p_clear) else $error("status write did not clear");
    a_add_mixed: assert property (p_add_mixed) else $error("mixed sign sum wrong");
    a_add_ovf: assert property (p_add_ovf) else $error("overflow not clamped");
    c_wide_sat: cover property (wide_op ##1 RSP.saturated);
    c_clear: cover property (STATUS_WR && !STATUS_WR_SAT && SAT_FLAG);
    c_lane: cover property (REQ.valid && !wide_op);
endmodule // ssu_checker
`default_nettype wire

// [testbench/ssu_pipe_model.sv]
// Pipeline model that issues operations and status writes to the unit.
`timescale 1ns/100ps
`default_nettype none
module ssu_pipe_model
    import ssu_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire ssu_rsp_s   rsp_i,
    input  wire logic       sat_flag,
    input  wire logic [3:0] nzcv_out,
    output var  ssu_req_s   req,
    output var  logic       status_wr,
    output var  logic       status_wr_sat,
    output var  logic [3:0] nzcv_in
);
    initial begin
        req           = '0;
        status_wr     = 1'b0;
        status_wr_sat = 1'b0;
        nzcv_in       = 4'h0;
    end
    // Operands are plain data values; no stack or program pointer is ever sent.
    task automatic issue(input ssu_op_e op, input logic [31:0] a, input logic [31:0] b,
                         output ssu_rsp_s rsp, output logic flag, output logic [3:0] nz);
        @(posedge ref_clk);
        req     <= '{1'b1, op, a, b};
        nzcv_in <= 4'(op);
        @(posedge ref_clk);
        req     <= '{1'b0, op, ~a, ~b};
        #1;
        rsp  = rsp_i;
        flag = sat_flag;
        nz   = nzcv_out;
    endtask
    // Writes the flag and reads it back from the sat_flag output.
    task automatic write_flag(input logic v, output logic flag);
        @(posedge ref_clk);
        status_wr     <= 1'b1;
        status_wr_sat <= v;
        @(posedge ref_clk);
        status_wr     <= 1'b0;
        status_wr_sat <= ~v;
        #1;
        flag = sat_flag;
    endtask
endmodule // ssu_pipe_model
`default_nettype wire

// [testbench/test_ssu_unit.sv]
// Self-checking testbench of the saturating unit.
`timescale 1ns/100ps
`default_nettype none
module test_ssu_unit;
    import ssu_pkg::*;
    logic       ref_clk = 1'b0;
    logic       rst_n = 1'b0;
    ssu_req_s   req;
    ssu_rsp_s   rsp;
    logic       status_wr;
    logic       status_wr_sat;
    logic       sat_flag;
    logic [3:0] nzcv_in;
    logic [3:0] nzcv_out;
    int         error_cnt = 0;
    int         checks = 0;
    int         cycles = 0;
    always #50 ref_clk = ~ref_clk;
    ssu_unit i_ssu_unit (.REF_CLK(ref_clk), .RST_N(rst_n), .REQ(req), .STATUS_WR(status_wr),
        .STATUS_WR_SAT(status_wr_sat), .NZCV_IN(nzcv_in), .RSP(rsp), .SAT_FLAG(sat_flag),
        .NZCV_OUT(nzcv_out));
    ssu_pipe_model i_ssu_pipe_model (.ref_clk(ref_clk), .rsp_i(rsp), .sat_flag(sat_flag),
        .nzcv_out(nzcv_out), .req(req), .status_wr(status_wr), .status_wr_sat(status_wr_sat),
        .nzcv_in(nzcv_in));
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic cmp32(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cmp1(input string what, input logic seen, input logic exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %b seen %b", what, exp, seen);
        end
    endtask
    task automatic do_op(input ssu_op_e op, input logic [31:0] a, input logic [31:0] b,
                         input logic [31:0] exp, input logic ef, input logic es);
        ssu_rsp_s   r;
        logic       f;
        logic [3:0] n;
        i_ssu_pipe_model.issue(op, a, b, r, f, n);
        cmp1("valid", r.valid, 1'b1);
        cmp32("result", r.result, exp);
        cmp1("flag", f, ef);
        cmp1("saturated", r.saturated, es);
        cmp32("nzcv", {28'h0, n}, {28'h0, 4'(op)});
    endtask
    task automatic set_flag(input logic v);
        logic f;
        i_ssu_pipe_model.write_flag(v, f);
        cmp1("flag write", f, v);
    endtask
    task automatic t_wide;
        do_op(SSU_OP_SIGNED_SAT_ADD, 32'h7FFF_FFFF, 32'h0000_0001,
              32'h7FFF_FFFF, 1'b1, 1'b1);
        do_op(SSU_OP_SIGNED_SAT_SUB, 32'h8000_0000, 32'h0000_0001,
              32'h8000_0000, 1'b1, 1'b1);
        set_flag(1'b0);
        do_op(SSU_OP_SIGNED_SAT_ADD, 32'h0000_0005, 32'hFFFF_FFFE,
              32'h0000_0003, 1'b0, 1'b0);
        do_op(SSU_OP_SIGNED_SAT_SUB, 32'h0000_0003, 32'h0000_0005,
              32'hFFFF_FFFE, 1'b0, 1'b0);
        $display("test wide done");
    endtask
    task automatic t_lanes;
        set_flag(1'b1);
        do_op(SSU_OP_SIGNED_SAT_ADD_BYTES, 32'h7F80_10F0, 32'h01FF_20F0,
              32'h7F80_30E0, 1'b1, 1'b1);
        set_flag(1'b0);
        do_op(SSU_OP_SIGNED_SAT_ADD_BYTES, 32'h7F80_10F0, 32'h01FF_20F0,
              32'h7F80_30E0, 1'b0, 1'b1);
        do_op(SSU_OP_SIGNED_SAT_ADD_HALVES, 32'h7FFF_0001, 32'h0001_0002,
              32'h7FFF_0003, 1'b0, 1'b1);
        do_op(SSU_OP_SIGNED_SAT_SUB_BYTES, 32'h807F_0500, 32'h01FF_0301,
              32'h807F_02FF, 1'b0, 1'b1);
        do_op(SSU_OP_SIGNED_SAT_SUB_HALVES, 32'h8000_0005, 32'h0001_0007,
              32'h8000_FFFE, 1'b0, 1'b1);
        do_op(SSU_OP_SIGNED_ADD_SUB_EXCHANGE, 32'h1000_2000, 32'h0003_0005,
              32'h1005_1FFD, 1'b0, 1'b0);
        do_op(SSU_OP_SIGNED_ADD_SUB_EXCHANGE, 32'h7FFF_8000, 32'h0002_0003,
              32'h7FFF_8000, 1'b0, 1'b1);
        do_op(SSU_OP_SIGNED_SUB_ADD_EXCHANGE, 32'h1000_2000, 32'h0003_0005,
              32'h0FFB_2003, 1'b0, 1'b0);
        $display("test signed lanes done");
    endtask
    task automatic t_doubling;
        do_op(SSU_OP_DOUBLING_SAT_ADD, 32'h0000_0005, 32'h0000_0002,
              32'h0000_0009, 1'b0, 1'b0);
        do_op(SSU_OP_DOUBLING_SAT_SUB, 32'h0000_000A, 32'h0000_0003,
              32'h0000_0004, 1'b0, 1'b0);
        do_op(SSU_OP_DOUBLING_SAT_ADD, 32'h0000_0001, 32'h4000_0000,
              32'h7FFF_FFFF, 1'b1, 1'b1);
        set_flag(1'b0);
        do_op(SSU_OP_DOUBLING_SAT_SUB, 32'h0000_0000, 32'hC000_0000,
              32'h7FFF_FFFF, 1'b1, 1'b1);
        set_flag(1'b0);
        $display("test doubling done");
    endtask
    task automatic t_unsigned;
        do_op(SSU_OP_UNSIGNED_ADD_SUB_EXCHANGE, 32'hFFFF_0001, 32'h0005_0002,
              32'hFFFF_0000, 1'b0, 1'b1);
        do_op(SSU_OP_UNSIGNED_SUB_ADD_EXCHANGE, 32'h0003_FFF0, 32'h0020_0004,
              32'h0000_FFFF, 1'b0, 1'b1);
        do_op(SSU_OP_UNSIGNED_SAT_ADD_HALVES, 32'hFFF0_1234, 32'h0020_0001,
              32'hFFFF_1235, 1'b0, 1'b1);
        do_op(SSU_OP_UNSIGNED_SAT_ADD_BYTES, 32'hF001_807F, 32'h2002_8001,
              32'hFF03_FF80, 1'b0, 1'b1);
        do_op(SSU_OP_UNSIGNED_SAT_SUB_HALVES, 32'h0005_1000, 32'h0006_0001,
              32'h0000_0FFF, 1'b0, 1'b1);
        do_op(SSU_OP_UNSIGNED_SAT_SUB_BYTES, 32'h0510_FF00, 32'h0601_0100,
              32'h000F_FE00, 1'b0, 1'b1);
        $display("test unsigned done");
    endtask
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            error_cnt++;
            print_verdict();
        end
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        cmp1("flag after reset", sat_flag, SSU_SAT_FLAG_RST);
        cmp32("nzcv after reset", {28'h0, nzcv_out}, {28'h0, SSU_NZCV_RST});
        t_wide();
        t_lanes();
        t_doubling();
        t_unsigned();
        print_verdict();
    end
endmodule // test_ssu_unit
bind ssu_unit ssu_checker i_ssu_checker (.REF_CLK(REF_CLK), .RST_N(RST_N), .REQ(REQ),
    .STATUS_WR(STATUS_WR), .STATUS_WR_SAT(STATUS_WR_SAT), .NZCV_IN(NZCV_IN), .RSP(RSP),
    .SAT_FLAG(SAT_FLAG), .NZCV_OUT(NZCV_OUT));
`default_nettype wire
